// [hdl/pmr_pkg.sv]
package pmr_pkg;

	// Register word and serial port address widths
	localparam int REG_W  = 24;
	localparam int ADDR_W = 6;

	// Register addresses on the serial control port
	localparam logic [ADDR_W-1:0] ADDR_USB  = 6'h32;
	localparam logic [ADDR_W-1:0] ADDR_LED0 = 6'h33;
	localparam logic [ADDR_W-1:0] ADDR_LED1 = 6'h34;
	localparam logic [ADDR_W-1:0] ADDR_LED2 = 6'h35;

	// USB supply configuration fields
	localparam int USB_ROLE_BIT  = 0;
	localparam int USB_REGEN_BIT = 3;
	localparam int USB_IDPU_BIT  = 8;
	localparam int USB_OTG_BIT   = 10;
	localparam logic [REG_W-1:0] USB_WMASK   = 24'h060509;
	localparam logic [REG_W-1:0] USB_RSTMASK = 24'h060500;
	localparam logic [REG_W-1:0] USB_RST_VAL = 24'h000000;
	localparam logic             REGEN_RST   = 1'h1;

	// Backlight driver field layout, main display and keypad
	localparam int HI_BIT   = 1;
	localparam int RAMP_BIT = 2;
	localparam int DUTY_LSB = 3;
	localparam int DUTY_W   = 6;
	localparam int CUR_LSB  = 9;
	localparam int CUR_W    = 3;
	// Auxiliary display sits this far above the main one
	localparam int AUX_OFS  = 12;

	// Red indicator field layout
	localparam int PER_LSB  = 0;
	localparam int PER_W    = 2;

	// LED control registers: address, writable bits, reset value
	localparam int N_LED = 3;
	localparam logic [ADDR_W-1:0] LED_ADDR [N_LED] =
		'{ADDR_LED0, ADDR_LED1, ADDR_LED2};
	localparam logic [REG_W-1:0] LED_WMASK [N_LED] =
		'{24'hffffff, 24'h007fff, 24'h000007};
	localparam logic [REG_W-1:0] LED_RST_VAL = 24'h000000;

	// Register port request
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [REG_W-1:0]  wdata;
	} pmr_req_t;

	// One backlight driver setting
	typedef struct packed {
		logic              high_current;
		logic              ramp_en;
		logic [DUTY_W-1:0] duty;
		logic [CUR_W-1:0]  current;
	} pmr_drv_t;

	// USB supply controls
	typedef struct packed {
		logic vbus_role_select;
		logic usb_regulator_enable;
		logic id_line_pullup_enable;
		logic otg_boost_enable;
	} pmr_usb_t;

	// Red indicator controls
	typedef struct packed {
		logic [PER_W-1:0] red_blink_period;
		logic             red_ramp_en;
	} pmr_red_t;

endpackage

// [hdl/pmr_field_reg.sv]
`timescale 1ns/100ps
module pmr_field_reg #(
	parameter int            W       = 24,
	parameter logic [W-1:0]  WMASK   = '1,
	parameter logic [W-1:0]  RST_VAL = '0
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	// Write port
	input  wire logic         wr_i,
	input  wire logic [W-1:0] wdata_i,
	// Stored word
	output logic      [W-1:0] q_o
);

	// Width must be usable
	if (W < 1) begin : g_bad_w
		$error("pmr_field_reg: W must be positive");
	end

	// Only writable bits are ever stored
	logic [W-1:0] q_d;
	assign q_d = wr_i ? (wdata_i & WMASK) : q_o;

	// Storage with reset to the masked default
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			q_o <= RST_VAL & WMASK;
		end else begin
			q_o <= q_d;
		end
	end

endmodule

// [hdl/pmr_regs.sv]
`timescale 1ns/100ps
// Notes on behaviour
// - USB config bit 0 selects VBUS role, read/write, untouched by reset.
// - Strap open: regulator enable bit 3 resets to 1, forced 1 on bad VBUS.
// - Strap grounded: reset leaves regulator enable; startup load loads it.
// - USB config bit 8 enables ID line pull-up; clears on reset.
// - USB config bit 10 enables OTG boost switcher; clears on reset.
// - LED0 bit 1 selects main display high current; resets to 0.
// - LED0 bit 2 enables main display ramping; resets to 0.
// - LED0 bits 8..3 main display duty, bit 3 LSB; resets to 0.
// - LED0 bits 11..9 main display current setting; resets to 0.
// - LED0 bit 13 selects auxiliary display high current; resets 0.
// - LED0 bit 14 enables auxiliary display ramping; resets to 0.
// - LED0 bits 20..15 auxiliary duty, bit 15 LSB; resets to 0.
// - LED0 bits 23..21 auxiliary current setting; resets to 0.
// - LED1 bit 1 selects keypad high current; resets to 0.
// - LED1 bit 2 enables keypad ramping; resets to 0.
// - LED1 bits 8..3 keypad duty, bit 3 LSB; resets to 0.
// - LED1 bits 11..9 keypad current setting; resets to 0.
// - LED2 bits 1..0 red blink period; resets to 0.
// - LED2 bit 2 enables red channel ramping; resets to 0.
module pmr_regs #(
	parameter int REG_W = pmr_pkg::REG_W
) (
	// Clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              rst_n_i,
	// Serial control port register access
	input  pmr_pkg::pmr_req_t      req_i,
	output logic [REG_W-1:0]       reg_rdata_o,
	// Strap, VBUS state and startup configuration
	input  wire logic              regulator_setup_strap_open_i,
	input  wire logic              vbus_invalid_i,
	input  wire logic              startup_load_i,
	input  wire logic              startup_vbus_role_i,
	input  wire logic              startup_usb_reg_en_i,
	// Controls to the analog drivers
	output pmr_pkg::pmr_usb_t      usb_o,
	output pmr_pkg::pmr_drv_t      main_disp_o,
	output pmr_pkg::pmr_drv_t      aux_disp_o,
	output pmr_pkg::pmr_drv_t      keypad_o,
	output pmr_pkg::pmr_red_t      red_o
);

	// The field layout is fixed to the 24-bit word
	if (REG_W != pmr_pkg::REG_W) begin : g_bad_w
		$error("pmr_regs: REG_W must match the package word width");
	end

	// Address match, used by every register
	function automatic logic addr_hit(
		input logic [pmr_pkg::ADDR_W-1:0] a,
		input logic [pmr_pkg::ADDR_W-1:0] t
	);
		return a == t;
	endfunction

	// Pull one driver setting out of a register at a bit offset
	function automatic pmr_pkg::pmr_drv_t drv_of(
		input logic [REG_W-1:0] r,
		input int               ofs
	);
		pmr_pkg::pmr_drv_t d;
		d.high_current = r[ofs + pmr_pkg::HI_BIT];
		d.ramp_en      = r[ofs + pmr_pkg::RAMP_BIT];
		d.duty         = r[ofs + pmr_pkg::DUTY_LSB +: pmr_pkg::DUTY_W];
		d.current      = r[ofs + pmr_pkg::CUR_LSB +: pmr_pkg::CUR_W];
		return d;
	endfunction

	// LED control storage
	logic [REG_W-1:0] led_q   [pmr_pkg::N_LED];
	logic             led_hit [pmr_pkg::N_LED];
	logic             led_wr  [pmr_pkg::N_LED];

	// One plain register per LED control word
	for (genvar i = 0; i < pmr_pkg::N_LED; i++) begin : g_led
		assign led_hit[i] = addr_hit(req_i.addr, pmr_pkg::LED_ADDR[i]);
		assign led_wr[i]  = req_i.wr && led_hit[i];
		pmr_field_reg #(
			.W       (REG_W),
			.WMASK   (pmr_pkg::LED_WMASK[i]),
			.RST_VAL (pmr_pkg::LED_RST_VAL)
		) pmr_field_reg_inst (
			.clk_i   (sys_clk_i),
			.rst_n_i (rst_n_i),
			.wr_i    (led_wr[i]),
			.wdata_i (req_i.wdata),
			.q_o     (led_q[i])
		);
	end

	// USB supply configuration decode
	logic             usb_hit;
	logic             usb_wr;
	logic [REG_W-1:0] usb_wval;
	assign usb_hit  = addr_hit(req_i.addr, pmr_pkg::ADDR_USB);
	assign usb_wr   = req_i.wr && usb_hit;
	assign usb_wval = req_i.wdata & pmr_pkg::USB_WMASK;

	// USB state: role, regulator enable, reset-cleared bits
	logic             role_q;
	logic             role_d;
	logic             regen_q;
	logic             regen_d;
	logic [REG_W-1:0] usb_rst_q;
	logic [REG_W-1:0] usb_rst_d;

	// Role: software write beats the startup load
	assign role_d = usb_wr ? usb_wval[pmr_pkg::USB_ROLE_BIT] :
		startup_load_i ? startup_vbus_role_i : role_q;

	// Regulator enable: bad VBUS forces on, then write, then startup
	assign regen_d = vbus_invalid_i ? 1'h1 :
		usb_wr ? usb_wval[pmr_pkg::USB_REGEN_BIT] :
		startup_load_i ? startup_usb_reg_en_i : regen_q;

	// Bits that general reset clears
	assign usb_rst_d = usb_wr ? (usb_wval & pmr_pkg::USB_RSTMASK) :
		usb_rst_q;

	// Role is never touched by general reset
	always_ff @(posedge sys_clk_i) begin
		role_q <= rst_n_i ? role_d : role_q;
	end

	// Regulator enable reset depends on the strap
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			if (regulator_setup_strap_open_i) begin
				regen_q <= pmr_pkg::REGEN_RST;
			end
		end else begin
			regen_q <= regen_d;
		end
	end

	// Pull-up, OTG boost and spare storage
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			usb_rst_q <= pmr_pkg::USB_RST_VAL;
		end else begin
			usb_rst_q <= usb_rst_d;
		end
	end

	// Assembled USB word as software sees it
	logic [REG_W-1:0] usb_view;
	always_comb begin
		usb_view = usb_rst_q;
		usb_view[pmr_pkg::USB_ROLE_BIT]  = role_q;
		usb_view[pmr_pkg::USB_REGEN_BIT] = regen_q;
	end

	// Read selection; unmapped addresses read zero
	logic [REG_W-1:0] rd_mux;
	assign rd_mux = usb_hit    ? usb_view :
			led_hit[0] ? led_q[0] :
			led_hit[1] ? led_q[1] :
			led_hit[2] ? led_q[2] : '0;

	// Read data is captured on a read strobe and then held
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= '0;
		end else if (req_i.rd) begin
			reg_rdata_o <= rd_mux;
		end
	end

	// USB controls to the analog side
	assign usb_o.vbus_role_select      = role_q;
	assign usb_o.usb_regulator_enable  = regen_q;
	assign usb_o.id_line_pullup_enable =
		usb_rst_q[pmr_pkg::USB_IDPU_BIT];
	assign usb_o.otg_boost_enable      =
		usb_rst_q[pmr_pkg::USB_OTG_BIT];

	// Backlight driver settings
	assign main_disp_o = drv_of(led_q[0], 0);
	assign aux_disp_o  = drv_of(led_q[0],
		pmr_pkg::AUX_OFS);
	assign keypad_o    = drv_of(led_q[1], 0);

	// Red indicator settings
	assign red_o.red_blink_period =
		led_q[2][pmr_pkg::PER_LSB +: pmr_pkg::PER_W];
	assign red_o.red_ramp_en = led_q[2][pmr_pkg::RAMP_BIT];

	// Checks: sequences used by the properties below
	sequence s_leave_reset;
		$rose(rst_n_i);
	endsequence

	sequence s_wr_usb;
		req_i.wr && usb_hit && !vbus_invalid_i;
	endsequence

	sequence s_wr_led(int k);
		req_i.wr && addr_hit(req_i.addr, pmr_pkg::LED_ADDR[k]);
	endsequence

	// Role holds its value across reset
	property p_role_keep;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_leave_reset |-> usb_o.vbus_role_select ===
			$past(usb_o.vbus_role_select);
	endproperty
	a_role_keep: assert property (p_role_keep)
		else $error("VBUS role changed across reset");

	// Strap open: regulator enable is 1 after reset
	property p_regen_open;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_leave_reset ##0 $past(regulator_setup_strap_open_i)
			|-> usb_o.usb_regulator_enable;
	endproperty
	a_regen_open: assert property (p_regen_open)
		else $error("Regulator enable not set by reset");

	// Bad VBUS forces the regulator on next cycle, and without a write or startup load then it stays on a cycle more
	property p_regen_vbus;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		vbus_invalid_i ##1 (!usb_wr && !startup_load_i) |->
			usb_o.usb_regulator_enable [*2];
	endproperty
	a_regen_vbus: assert property (p_regen_vbus)
		else $error("Regulator enable not forced on bad VBUS");

	// Strap grounded: reset leaves the regulator enable alone
	property p_regen_gnd;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_leave_reset ##0 !$past(regulator_setup_strap_open_i)
			|-> usb_o.usb_regulator_enable ===
			$past(usb_o.usb_regulator_enable);
	endproperty
	a_regen_gnd: assert property (p_regen_gnd)
		else $error("Regulator enable changed by reset");

	// Pull-up and boost are cleared after reset
	property p_usb_clear;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_leave_reset |-> !usb_o.id_line_pullup_enable &&
			!usb_o.otg_boost_enable;
	endproperty
	a_usb_clear: assert property (p_usb_clear)
		else $error("USB pull-up or boost set after reset");

	// Write to the USB word reaches the boost and pull-up
	property p_usb_write;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_wr_usb |=> usb_o.otg_boost_enable ==
			$past(req_i.wdata[pmr_pkg::USB_OTG_BIT]) &&
			usb_o.id_line_pullup_enable ==
			$past(req_i.wdata[pmr_pkg::USB_IDPU_BIT]);
	endproperty
	a_usb_write: assert property (p_usb_write)
		else $error("USB write did not land");

	// All LED settings read zero after reset
	property p_led_clear;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_leave_reset |-> main_disp_o == '0 && aux_disp_o == '0 &&
			keypad_o == '0 && red_o == '0;
	endproperty
	a_led_clear: assert property (p_led_clear)
		else $error("LED settings not cleared by reset");

	// Main and auxiliary fields follow the written word
	property p_led0_write;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_wr_led(0) |=> main_disp_o.duty ==
			$past(req_i.wdata[8:3]) &&
			aux_disp_o.current == $past(req_i.wdata[23:21]) &&
			aux_disp_o.high_current == $past(req_i.wdata[13]);
	endproperty
	a_led0_write: assert property (p_led0_write)
		else $error("Display field mismatch after write");

	// Keypad fields follow the written word
	property p_led1_write;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_wr_led(1) |=> keypad_o.current ==
			$past(req_i.wdata[11:9]) &&
			keypad_o.ramp_en == $past(req_i.wdata[2]);
	endproperty
	a_led1_write: assert property (p_led1_write)
		else $error("Keypad field mismatch after write");

	// Red fields follow the written word
	property p_led2_write;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_wr_led(2) |=> red_o.red_blink_period ==
			$past(req_i.wdata[1:0]);
	endproperty
	a_led2_write: assert property (p_led2_write)
		else $error("Red period mismatch after write");

	// Without a write the main display and keypad settings stay put
	property p_led_stable;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		!req_i.wr |=> $stable(main_disp_o) && $stable(keypad_o);
	endproperty
	a_led_stable: assert property (p_led_stable)
		else $error("LED setting changed without a write");

	// Reserved bits of a read word are zero
	property p_rd_reserved;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		req_i.rd ##0 (usb_hit || led_hit[1] || led_hit[2]) |=>
			(reg_rdata_o & ~($past(usb_hit) ? pmr_pkg::USB_WMASK :
			$past(led_hit[1]) ? pmr_pkg::LED_WMASK[1] :
			pmr_pkg::LED_WMASK[2])) == '0;
	endproperty
	a_rd_reserved: assert property (p_rd_reserved)
		else $error("Reserved bit read as one");

	// Spare keypad bits read back what was written
	property p_spare_rb;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_wr_led(1) ##1 (req_i.rd && led_hit[1] && !req_i.wr)
			|=> reg_rdata_o[14:12] == $past(req_i.wdata[14:12], 2);
	endproperty
	a_spare_rb: assert property (p_spare_rb)
		else $error("Keypad spare bits lost");

	// Main display fields beyond duty follow the written word
	property p_main_write;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_wr_led(0) |=> main_disp_o.high_current ==
			$past(req_i.wdata[1]) &&
			main_disp_o.ramp_en == $past(req_i.wdata[2]) &&
			main_disp_o.current == $past(req_i.wdata[11:9]);
	endproperty
	a_main_write: assert property (p_main_write)
		else $error("Main display field mismatch after write");

	// Red ramp enable follows the written word
	property p_red_ramp;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_wr_led(2) |=> red_o.red_ramp_en ==
			$past(req_i.wdata[2]);
	endproperty
	a_red_ramp: assert property (p_red_ramp)
		else $error("Red ramp enable mismatch after write");

	// Without a write the auxiliary and red settings stay put
	property p_led_hold;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		!req_i.wr |=> $stable(aux_disp_o) && $stable(red_o);
	endproperty
	a_led_hold: assert property (p_led_hold)
		else $error("Auxiliary or red setting changed without a write");

endmodule

// [tb/usb_supply_and_backlight_regs_tb.sv]
`timescale 1ns/100ps
module usb_supply_and_backlight_regs_tb;

	// Design inputs
	logic                 sys_clk_i;
	logic                 rst_n_i;
	pmr_pkg::pmr_req_t    req_i;
	logic                 strap_open;
	logic                 vbus_inv;
	logic                 st_load;
	logic                 st_role;
	logic                 st_regen;
	// Design outputs
	logic [23:0]          reg_rdata_o;
	pmr_pkg::pmr_usb_t    usb_o;
	pmr_pkg::pmr_drv_t    main_disp_o;
	pmr_pkg::pmr_drv_t    aux_disp_o;
	pmr_pkg::pmr_drv_t    keypad_o;
	pmr_pkg::pmr_red_t    red_o;
	// Reference model state and bookkeeping
	logic [23:0]          m_usb;
	logic [23:0]          m_led [3];
	logic [23:0]          m_rd;
	logic                 usb_known = 1'h0;
	int                   failures = 0;
	int                   comparisons = 0;
	int                   seed;
	logic [31:0]          r;

	pmr_regs pmr_regs_inst (
		.sys_clk_i                    (sys_clk_i),
		.rst_n_i                      (rst_n_i),
		.req_i                        (req_i),
		.reg_rdata_o                  (reg_rdata_o),
		.regulator_setup_strap_open_i (strap_open),
		.vbus_invalid_i               (vbus_inv),
		.startup_load_i               (st_load),
		.startup_vbus_role_i          (st_role),
		.startup_usb_reg_en_i         (st_regen),
		.usb_o                        (usb_o),
		.main_disp_o                  (main_disp_o),
		.aux_disp_o                   (aux_disp_o),
		.keypad_o                     (keypad_o),
		.red_o                        (red_o)
	);

	// Free running 20 MHz clock
	initial begin
		sys_clk_i = 1'h0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end

	// Model read of one address, unmapped reads 0
	function automatic logic [23:0] rdv(logic [5:0] a);
		logic [23:0] v;
		v = 24'h000000;
		if (a == pmr_pkg::ADDR_USB) v = m_usb;
		for (int k = 0; k < 3; k++) begin
			if (a == pmr_pkg::LED_ADDR[k]) v = m_led[k];
		end
		return v;
	endfunction

	// Driver fields from a word, layout starting at bit 0
	function automatic pmr_pkg::pmr_drv_t drv(logic [23:0] w);
		return {w[1], w[2], w[8:3], w[11:9]};
	endfunction

	// Model update on each rising edge
	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			m_led = '{24'h000000, 24'h000000, 24'h000000};
			m_usb = m_usb & 24'h000009;
			if (strap_open) m_usb[3] = 1'h1;
			m_rd = 24'h000000;
		end else begin
			if (req_i.rd) m_rd = rdv(req_i.addr);
			if (st_load) begin
				m_usb[0] = st_role;
				m_usb[3] = st_regen;
				usb_known = 1'h1;
			end
			if (req_i.wr && req_i.addr == pmr_pkg::ADDR_USB)
				m_usb = req_i.wdata & pmr_pkg::USB_WMASK;
			for (int k = 0; k < 3; k++) begin
				if (req_i.wr && req_i.addr == pmr_pkg::LED_ADDR[k])
					m_led[k] = req_i.wdata & pmr_pkg::LED_WMASK[k];
			end
			if (vbus_inv) m_usb[3] = 1'h1;
		end
	end

	// One comparison, counted
	task automatic chk(string n, logic [23:0] e, logic [23:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	// Compare each output once per cycle, away from the edge; usb_o only once a startup load has set usb_known
	always @(negedge sys_clk_i) begin
		chk("reg_rdata_o", m_rd, reg_rdata_o);
		chk("main_disp_o",
			24'(drv(m_led[0])), 24'(main_disp_o));
		chk("aux_disp_o",
			24'(drv(m_led[0] >> 12)), 24'(aux_disp_o));
		chk("keypad_o",
			24'(drv(m_led[1])), 24'(keypad_o));
		chk("red_o",
			24'({m_led[2][1:0], m_led[2][2]}), 24'(red_o));
		if (usb_known)
			chk("usb_o",
				24'({m_usb[0], m_usb[3], m_usb[8], m_usb[10]}),
				24'(usb_o));
	end

	// Drive one cycle of requests
	task automatic drive(logic wr, logic rd, logic [5:0] a, logic [23:0] d,
		logic vb, logic ld);
		@(negedge sys_clk_i);
		req_i.wr    = wr;
		req_i.rd    = rd;
		req_i.addr  = a;
		req_i.wdata = d;
		vbus_inv    = vb;
		st_load     = ld;
	endtask

	// General reset for four cycles
	task automatic do_reset();
		drive(1'h0, 1'h0, 6'h00, 24'h000000, 1'h0, 1'h0);
		rst_n_i = 1'h0;
		repeat (4) @(negedge sys_clk_i);
		rst_n_i = 1'h1;
	endtask

	task automatic summarize();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Main sequence
	initial begin
		seed = 44;
		req_i = '0;
		rst_n_i = 1'h0;
		strap_open = 1'h1;
		vbus_inv = 1'h0;
		st_load = 1'h0;
		st_role = 1'h1;
		st_regen = 1'h0;
		repeat (4) @(negedge sys_clk_i);
		rst_n_i = 1'h1;
		// Startup load of role and regulator enable
		drive(1'h0, 1'h0, 6'h00, 24'h000000, 1'h0, 1'h1);
		// Reset values, then all ones with read in the same cycle
		for (int a = 6'h30; a < 6'h38; a++) begin
			drive(1'h0, 1'h1, 6'(a), 24'h000000, 1'h0, 1'h0);
			drive(1'h1, 1'h1, 6'(a), 24'hffffff, 1'h0, 1'h0);
			drive(1'h0, 1'h1, 6'(a), 24'h000000, 1'h0, 1'h0);
		end
		// Bad VBUS beats a software clear, then clear sticks
		drive(1'h1, 1'h0, pmr_pkg::ADDR_USB, 24'h000000, 1'h1, 1'h0);
		drive(1'h1, 1'h1, pmr_pkg::ADDR_USB, 24'h000000, 1'h0, 1'h0);
		// Random traffic over mapped and unmapped addresses
		repeat (400) begin
			r = $random(seed);
			drive(r[0], r[1], 6'h30 | 6'(r[4:2]), 24'($random(seed)),
				r[5] & r[6] & r[7], r[8] & r[9] & r[10]);
			st_role = r[11];
			st_regen = r[12];
		end
		// Strap grounded: reset keeps role and regulator enable
		drive(1'h1, 1'h0, pmr_pkg::ADDR_USB, 24'h000501, 1'h0, 1'h0);
		strap_open = 1'h0;
		do_reset();
		drive(1'h0, 1'h1, pmr_pkg::ADDR_USB, 24'h000000, 1'h0, 1'h0);
		drive(1'h1, 1'h0, pmr_pkg::ADDR_USB, 24'h000008, 1'h0, 1'h0);
		do_reset();
		// Strap open: reset sets regulator enable again
		drive(1'h1, 1'h0, pmr_pkg::ADDR_USB, 24'h000000, 1'h0, 1'h0);
		strap_open = 1'h1;
		do_reset();
		drive(1'h0, 1'h1, pmr_pkg::ADDR_USB, 24'h000000, 1'h0, 1'h0);
		drive(1'h0, 1'h0, 6'h00, 24'h000000, 1'h0, 1'h0);
		drive(1'h0, 1'h0, 6'h00, 24'h000000, 1'h0, 1'h0);
		summarize();
	end

endmodule
